// file: common/timer_core_pkg.sv
// Constants shared by the 16-bit timer counter core: register map,
// field positions, reset values, mode codes and clock figures.
// Assumes a 32-bit classic Wishbone register bus, one register per word.
`default_nettype none

package timer_core_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock figures
    localparam int SYS_CLK_HZ     = 20_000_000; // System clock rate
    localparam int TICK_MIN_HZ    = 250_000;    // Slowest global tick allowed
    localparam int TICK_MAX_HZ    = 32_000_000; // Fastest tick, crystal source
    localparam int RC_TICK_MAX_HZ = 16_000_000; // Fastest tick, RC source

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [5:0] OFS_CTRL     = 6'h00; // timer_control_status
    localparam logic [5:0] OFS_CNT_LO   = 6'h04; // count_low_byte
    localparam logic [5:0] OFS_CNT_HI   = 6'h08; // count_high_byte
    localparam logic [5:0] OFS_IRQ_MASK = 6'h0C; // timer_irq_mask_reg
    localparam logic [5:0] OFS_TICK_DIV = 6'h10; // global_tick_divider
    localparam logic [5:0] OFS_CH_CTL0  = 6'h14; // Channel controls, 4 apart
    localparam logic [5:0] OFS_CH_VAL0  = 6'h20; // Channel values, 4 apart

    ////////////////////////////////////////////////////////////////////////
    // timer_control_status fields
    localparam int CTL_MODE_LSB = 0; // count_mode_field, 2 bits
    localparam int CTL_DIV_LSB  = 2; // prescale_select, 2 bits
    localparam int CTL_OVF_BIT  = 4; // overflow_flag
    localparam int CTL_CHF_LSB  = 5; // Channel flags, 3 bits
    localparam int IRQ_OVF_BIT  = 0; // overflow_irq_mask in the mask register

    // Channel control fields
    localparam int CH_IM_BIT    = 0; // Channel interrupt mask
    localparam int CH_SRC_BIT   = 1; // Capture source: 0 pin, 1 radio event
    localparam int CH_CMP_BIT   = 2; // 0 capture, 1 compare
    localparam int CH_EDGE_LSB  = 3; // Capture edge, 2 bits
    localparam int CH_ACT_LSB   = 5; // Compare action, 2 bits
    localparam int CH_CTL_W     = 7; // Width of a channel control register

    // Capture edge and compare action codes
    localparam logic [1:0] EDGE_RISE  = 2'h1;
    localparam logic [1:0] EDGE_FALL  = 2'h2;
    localparam logic [1:0] EDGE_BOTH  = 2'h3;
    localparam logic [1:0] ACT_SET    = 2'h0;
    localparam logic [1:0] ACT_CLEAR  = 2'h1;
    localparam logic [1:0] ACT_TOGGLE = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Count modes and values
    typedef enum logic [1:0] {
        MODE_HALT   = 2'h0,
        MODE_FREE   = 2'h1,
        MODE_MODULO = 2'h2,
        MODE_UPDOWN = 2'h3
    } count_mode_t;

    localparam logic [15:0] COUNT_ZERO  = 16'h0000;
    localparam logic [15:0] COUNT_TERM  = 16'hFFFF;
    localparam logic [2:0]  TICKDIV_RST = 3'h0;    // Global tick = clk_sys
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

endpackage : timer_core_pkg

`default_nettype wire

// file: design/timer_counter_core.sv
// 16-bit timer counter core with three capture/compare channels.
// Assumes a classic Wishbone master, pin inputs synchronous to clk_sys,
// and a one-cycle radio event pulse from the radio block.
//
// Function
// - 16-bit count steps once per prescaled tick
// - Local prescaler divides by 1, 8, 32, 128
// - Global tick divides system clock, bounded range
// - RC clock source limits tick to 16 MHz
// - Low-byte read latches high byte coherently
// - Low-byte write with byte lane 0 selected clears whole counter
// - Nonzero mode runs; zero mode halts, holds value
// - Free-run counts 0 to FFFF, wraps
// - Free-run sets overflow flag at FFFF
// - Overflow request needs flag and mask
// - Modulo counts to channel-0 value, restarts
// - Modulo sets overflow flag at terminal value
// - Three channels, one pin each
// - Capture on rising, falling or either edge
// - Compare sets, clears or toggles pin
// - Requests on capture, compare and terminal count
// - Radio event capture; compare triggers DMA
// - Up/down counts to channel-0 value and back
// - Low-byte write forces direction up
`default_nettype none

module timer_counter_core #(
    parameter int          NUM_CH          = 3,       // Capture/compare channels
    parameter int          CLK_HZ          = timer_core_pkg::SYS_CLK_HZ,
    parameter bit          RC_CLOCK_SOURCE = 1'b0     // Clocked from RC oscillator
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [5:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Channel pins and events
    input  wire logic [NUM_CH-1:0] ch_pin_in,
    output logic      [NUM_CH-1:0] ch_pin_out,
    output logic      [NUM_CH-1:0] ch_pin_oe,
    input  wire logic              radio_event,
    output logic      [NUM_CH-1:0] dma_trigger,
    output logic                   irq_request
);

    ////////////////////////////////////////////////////////////////////////
    // Elaboration checks
    localparam int TICK_LIMIT_HZ = RC_CLOCK_SOURCE ? timer_core_pkg::RC_TICK_MAX_HZ
                                                   : timer_core_pkg::TICK_MAX_HZ;
    initial begin
        // Fastest tick is the undivided clock, so the clock itself must fit
        if (CLK_HZ > TICK_LIMIT_HZ || CLK_HZ < timer_core_pkg::TICK_MIN_HZ) begin
            $error("clock rate outside the timer tick range");
        end
        if (NUM_CH != 3) begin
            $error("the register map serves exactly three channels");
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Terminal prescaler count for each prescale_select code
    function automatic logic [6:0] prescale_last(input logic [1:0] code);
        case (code)
            2'h0:    prescale_last = 7'h00; // Divide by 1
            2'h1:    prescale_last = 7'h07; // Divide by 8
            2'h2:    prescale_last = 7'h1F; // Divide by 32
            default: prescale_last = 7'h7F; // Divide by 128
        endcase
    endfunction : prescale_last

    // Merge the two low byte lanes of a write into a 16-bit register
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  sel);
        merge16[7:0]  = sel[0] ? new_v[7:0]  : old_v[7:0];
        merge16[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    endfunction : merge16

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    localparam int CH_CTL_W = timer_core_pkg::CH_CTL_W;
    logic        bus_req;               // New request this cycle
    logic        wr_req;                // Write request taken
    logic        rd_req;                // Read request taken
    logic        ack_q;                 // Registered acknowledge
    logic [31:0] dat_q;                 // Registered read data
    logic [1:0]  mode_q;                // count_mode_field
    logic [1:0]  prescale_q;            // prescale_select
    logic [2:0]  tick_div_q;            // global_tick_divider
    logic        ovf_mask_q;            // overflow_irq_mask
    logic        ovf_flag_q;            // overflow_flag
    logic [NUM_CH-1:0] ch_flag_q;       // Channel event flags
    logic [15:0] count_q;               // The counter
    logic [15:0] count_d;
    logic        down_q;                // Up/down direction, 1 counts down
    logic        down_d;
    logic        ovf_event;             // Terminal count reached this tick
    logic [7:0]  count_hi_q;            // Buffered high byte
    logic [6:0]  gdiv_q;                // Global tick divider counter
    logic [6:0]  gdiv_mask;
    logic        global_tick;
    logic [6:0]  pre_q;                 // Local prescaler counter
    logic        active_tick;           // Counter steps on this cycle
    logic        cnt_lo_write;          // Write to the low-byte register with byte lane 0 selected
    logic [CH_CTL_W-1:0] ch_ctl_q [NUM_CH];  // Channel controls
    logic [15:0] ch_val_q [NUM_CH];          // Capture/compare values
    logic [NUM_CH-1:0] pin_prev_q;           // Pin state one cycle back
    logic [NUM_CH-1:0] ch_event;             // Capture or compare event
    logic [NUM_CH-1:0] cmp_match;            // Compare match this tick
    logic [NUM_CH-1:0] cap_hit;              // Capture trigger this cycle
    logic [NUM_CH-1:0] ch_flag_clr;          // Software clearing channel flags
    logic [NUM_CH-1:0] ch_mask;              // Channel interrupt masks

    ////////////////////////////////////////////////////////////////////////
    // Wishbone handshake: request taken on the edge where it is first seen,
    // ack one cycle later; the extra cycle keeps ack low between requests.
    assign bus_req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_req       = bus_req && wb_we_i;
    assign rd_req       = bus_req && !wb_we_i;
    assign cnt_lo_write = wr_req && wb_adr_i == timer_core_pkg::OFS_CNT_LO && wb_sel_i[0];

    // Acknowledge every request, mapped or not
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // Read data mux, registered at the taking edge
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dat_q <= timer_core_pkg::RD_UNMAPPED;
        end else if (rd_req) begin
            dat_q <= timer_core_pkg::RD_UNMAPPED;
            case (wb_adr_i)
                timer_core_pkg::OFS_CTRL: begin
                    dat_q[timer_core_pkg::CTL_MODE_LSB +: 2] <= mode_q;
                    dat_q[timer_core_pkg::CTL_DIV_LSB +: 2]  <= prescale_q;
                    dat_q[timer_core_pkg::CTL_OVF_BIT]       <= ovf_flag_q;
                    dat_q[timer_core_pkg::CTL_CHF_LSB +: 3]  <= ch_flag_q;
                end
                timer_core_pkg::OFS_CNT_LO:   dat_q[7:0] <= count_q[7:0];
                timer_core_pkg::OFS_CNT_HI:   dat_q[7:0] <= count_hi_q;
                timer_core_pkg::OFS_IRQ_MASK: dat_q[timer_core_pkg::IRQ_OVF_BIT] <= ovf_mask_q;
                timer_core_pkg::OFS_TICK_DIV: dat_q[2:0] <= tick_div_q;
                default: begin
                    // Channel registers sit in two blocks of words
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (wb_adr_i == timer_core_pkg::OFS_CH_CTL0 + 6'(4 * i)) begin
                            dat_q[CH_CTL_W-1:0] <= ch_ctl_q[i];
                        end
                        if (wb_adr_i == timer_core_pkg::OFS_CH_VAL0 + 6'(4 * i)) begin
                            dat_q[15:0] <= ch_val_q[i];
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            mode_q     <= timer_core_pkg::MODE_HALT;
            prescale_q <= 2'h0;
            tick_div_q <= timer_core_pkg::TICKDIV_RST;
            ovf_mask_q <= 1'b0;
        end else if (wr_req && wb_sel_i[0]) begin
            if (wb_adr_i == timer_core_pkg::OFS_CTRL) begin
                mode_q     <= wb_dat_i[timer_core_pkg::CTL_MODE_LSB +: 2];
                prescale_q <= wb_dat_i[timer_core_pkg::CTL_DIV_LSB +: 2];
            end
            if (wb_adr_i == timer_core_pkg::OFS_IRQ_MASK) begin
                ovf_mask_q <= wb_dat_i[timer_core_pkg::IRQ_OVF_BIT];
            end
            if (wb_adr_i == timer_core_pkg::OFS_TICK_DIV) begin
                tick_div_q <= wb_dat_i[2:0];
            end
        end
    end

    // Channel control and value registers; a capture outranks a write
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_ctl_q[i] <= '0;
                ch_val_q[i] <= timer_core_pkg::COUNT_ZERO;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (wr_req && wb_sel_i[0] &&
                    wb_adr_i == timer_core_pkg::OFS_CH_CTL0 + 6'(4 * i)) begin
                    ch_ctl_q[i] <= wb_dat_i[CH_CTL_W-1:0];
                end
                if (cap_hit[i]) begin
                    ch_val_q[i] <= count_q;
                end else if (wr_req &&
                             wb_adr_i == timer_core_pkg::OFS_CH_VAL0 + 6'(4 * i)) begin
                    ch_val_q[i] <= merge16(ch_val_q[i], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tick generation: global tick divides clk_sys by 2**global_tick_divider,
    // the local prescaler divides that again.
    assign gdiv_mask   = 7'((8'h01 << tick_div_q) - 8'h01);
    assign global_tick = (gdiv_q & gdiv_mask) == gdiv_mask;
    assign active_tick = global_tick && pre_q == prescale_last(prescale_q)
                         && mode_q != timer_core_pkg::MODE_HALT;

    // Global divider runs freely so ticks stay evenly spaced
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            gdiv_q <= 7'h00;
        end else begin
            gdiv_q <= gdiv_q + 7'h01;
        end
    end

    // Prescaler restarts with the counter, so the first step after a
    // clear comes a full prescale period later
    always_ff @(posedge clk_sys) begin
        if (!nrst || cnt_lo_write) begin
            pre_q <= 7'h00;
        end else if (global_tick && mode_q != timer_core_pkg::MODE_HALT) begin
            if (pre_q == prescale_last(prescale_q)) begin
                pre_q <= 7'h00;
            end else begin
                pre_q <= pre_q + 7'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter next value
    always_comb begin
        count_d   = count_q;
        down_d    = down_q;
        ovf_event = 1'b0;
        if (cnt_lo_write) begin
            count_d = timer_core_pkg::COUNT_ZERO;
            down_d  = 1'b0;
        end else if (active_tick) begin
            case (mode_q)
                timer_core_pkg::MODE_FREE: begin
                    count_d = count_q + 16'h0001;
                    if (count_q == timer_core_pkg::COUNT_TERM) begin
                        ovf_event = 1'b1;
                    end
                end
                timer_core_pkg::MODE_MODULO: begin
                    if (count_q == ch_val_q[0]) begin
                        count_d   = timer_core_pkg::COUNT_ZERO;
                        ovf_event = 1'b1;
                    end else begin
                        count_d = count_q + 16'h0001;
                    end
                end
                timer_core_pkg::MODE_UPDOWN: begin
                    // Turn at the channel-0 value, terminal count at zero
                    if (!down_q && count_q >= ch_val_q[0]) begin
                        down_d  = 1'b1;
                        count_d = count_q - 16'h0001;
                    end else if (down_q && count_q == timer_core_pkg::COUNT_ZERO) begin
                        down_d    = 1'b0;
                        count_d   = count_q + 16'h0001;
                        ovf_event = 1'b1;
                    end else if (down_q) begin
                        count_d = count_q - 16'h0001;
                    end else begin
                        count_d = count_q + 16'h0001;
                    end
                end
                default: begin
                    count_d = count_q; // Halted: hold present value
                end
            endcase
        end
    end

    // Counter and direction
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            count_q <= timer_core_pkg::COUNT_ZERO;
            down_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            down_q  <= down_d;
        end
    end

    // High byte buffered at the instant the low byte is read
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            count_hi_q <= 8'h00;
        end else if (rd_req && wb_adr_i == timer_core_pkg::OFS_CNT_LO) begin
            count_hi_q <= count_q[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channels: capture edges, compare matches, pin drive
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            logic rise;
            logic fall;
            logic [1:0] edge_sel;
            rise     = ch_pin_in[i] && !pin_prev_q[i];
            fall     = !ch_pin_in[i] && pin_prev_q[i];
            edge_sel = ch_ctl_q[i][timer_core_pkg::CH_EDGE_LSB +: 2];
            ch_mask[i] = ch_ctl_q[i][timer_core_pkg::CH_IM_BIT];
            if (ch_ctl_q[i][timer_core_pkg::CH_CMP_BIT] ||
                mode_q == timer_core_pkg::MODE_HALT) begin
                cap_hit[i] = 1'b0;
            end else if (ch_ctl_q[i][timer_core_pkg::CH_SRC_BIT]) begin
                cap_hit[i] = radio_event && edge_sel != 2'h0;
            end else begin
                cap_hit[i] = (rise && (edge_sel == timer_core_pkg::EDGE_RISE ||
                                       edge_sel == timer_core_pkg::EDGE_BOTH)) ||
                             (fall && (edge_sel == timer_core_pkg::EDGE_FALL ||
                                       edge_sel == timer_core_pkg::EDGE_BOTH));
            end
            cmp_match[i] = active_tick && ch_ctl_q[i][timer_core_pkg::CH_CMP_BIT] &&
                           count_q == ch_val_q[i];
            ch_event[i]  = cap_hit[i] || cmp_match[i];
            ch_flag_clr[i] = wr_req && wb_sel_i[0] && wb_adr_i == timer_core_pkg::OFS_CTRL
                             && !wb_dat_i[timer_core_pkg::CTL_CHF_LSB + i];
        end
    end

    // Pin history for edge detection
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            pin_prev_q <= '0;
        end else begin
            pin_prev_q <= ch_pin_in;
        end
    end

    // Compare outputs; the pin is driven only in compare mode
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ch_pin_out <= '0;
            ch_pin_oe  <= '0;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                ch_pin_oe[i] <= ch_ctl_q[i][timer_core_pkg::CH_CMP_BIT];
                if (cmp_match[i]) begin
                    case (ch_ctl_q[i][timer_core_pkg::CH_ACT_LSB +: 2])
                        timer_core_pkg::ACT_SET:    ch_pin_out[i] <= 1'b1;
                        timer_core_pkg::ACT_CLEAR:  ch_pin_out[i] <= 1'b0;
                        timer_core_pkg::ACT_TOGGLE: ch_pin_out[i] <= !ch_pin_out[i];
                        default:                    ch_pin_out[i] <= ch_pin_out[i];
                    endcase
                end
            end
        end
    end

    // One-cycle DMA trigger per compare event
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            dma_trigger <= '0;
        end else begin
            dma_trigger <= cmp_match;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event flags: writing 0 clears, writing 1 leaves alone; a new event in
    // the clearing cycle wins so no terminal count is lost
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            ovf_flag_q <= 1'b0;
            ch_flag_q  <= '0;
        end else begin
            if (ovf_event) begin
                ovf_flag_q <= 1'b1;
            end else if (wr_req && wb_sel_i[0] && wb_adr_i == timer_core_pkg::OFS_CTRL &&
                         !wb_dat_i[timer_core_pkg::CTL_OVF_BIT]) begin
                ovf_flag_q <= 1'b0;
            end
            ch_flag_q <= ch_event | (ch_flag_q & ~ch_flag_clr);
        end
    end

    // Request is a level of pending flag and mask, so a mask set later
    // still raises it
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            irq_request <= 1'b0;
        end else begin
            irq_request <= (ovf_flag_q && ovf_mask_q) ||
                           |(ch_flag_q & ch_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus outputs
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule : timer_counter_core

`default_nettype wire

// file: testbench/timer_core_sva.sv
// Checker for the timer core bus handshake and pin outputs.
// Assumes it is bound to timer_counter_core and sees only its ports.
`default_nettype none
module timer_core_sva #(parameter int NUM_CH = 3) (
    input wire logic              clk_sys,
    input wire logic              nrst,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [5:0]        wb_adr_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [NUM_CH-1:0] ch_pin_out,
    input wire logic [NUM_CH-1:0] ch_pin_oe,
    input wire logic [NUM_CH-1:0] dma_trigger,
    input wire logic              irq_request
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o; // Request not yet answered
    a_ack_answer: assert property (req |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property ($rose(wb_ack_o) |-> $past(req)) else $error("ack unasked");
    a_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 6'h2C |=> !wb_dat_o)
        else $error("unmapped read not zero");
    a_oe_cause: assert property ($changed(ch_pin_oe) |-> $past(req && wb_we_i, 2))
        else $error("pin enable moved unasked");
    a_out_needs_oe: assert property ($changed(ch_pin_out) |-> $past(ch_pin_oe) != '0)
        else $error("pin level moved while not driven");
    a_dma_compare: assert property (|dma_trigger |-> !(dma_trigger & ~ch_pin_oe))
        else $error("dma pulse from capture channel");
    a_dma_pulse: assert property (|dma_trigger |=> dma_trigger == '0)
        else $error("dma pulse too long");
    // Reset must silence ack, request, pin enables and DMA triggers, so it is not disabled by reset itself
    a_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !wb_ack_o && !irq_request
        && ch_pin_oe == '0 && dma_trigger == '0) else $error("outputs live in reset");
    c_read: cover property (req && !wb_we_i);
    c_dma: cover property (|dma_trigger);
    c_irq: cover property ($rose(irq_request));
endmodule : timer_core_sva
bind timer_counter_core timer_core_sva #(.NUM_CH(NUM_CH)) chk_u (.*);
`default_nettype wire

// file: testbench/ext_pins_model.sv
// Far-side model: channel input pins and the radio event line.
// Assumes the bench raises fire for one cycle to get one pin-2 pulse.
`default_nettype none
module ext_pins_model (
    input  wire logic       clk_sys,
    input  wire logic       fire,
    output logic      [2:0] pin_lvl,
    output logic            radio_evt
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pulse spans a full clock so both edges are seen after synchronising
    always @(posedge clk_sys) pin_lvl <= fire ? 3'h4 : 3'h0;
    assign radio_evt = 1'b0; // Radio source left idle: no scenario selects it
endmodule : ext_pins_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench: drives the timer core over classic Wishbone.
// Assumes the checker is bound to the design and a 20 MHz clock.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 0, nrst = 0, cyc = 0, stb = 0, we = 0, fire = 0;
    logic [5:0]  adr = '0;
    logic [31:0] wdat = '0, rdat, dat_o;
    logic        ack, irq, radio;
    logic [2:0]  pins, pout, poe, dma, pin0;
    int          errors = 0, comparisons = 0, cycles = 0;
    always #25 clk_sys = ~clk_sys;
    ext_pins_model ext_u (.clk_sys(clk_sys), .fire(fire), .pin_lvl(pins), .radio_evt(radio));
    timer_counter_core dut_u (.clk_sys(clk_sys), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .ch_pin_in(pins), .ch_pin_out(pout), .ch_pin_oe(poe),
        .radio_event(radio), .dma_trigger(dma), .irq_request(irq));
    ////////////////////////////////////////////////////////////////////////
    // One classic cycle; holds the request until ack is sampled high
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
        do @(posedge clk_sys); while (ack !== 1'b1);
        rdat = dat_o;
        {cyc, stb} <= 2'h0;
        @(posedge clk_sys);
    endtask : wb
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Ceiling well above the longest run, the full 16-bit wrap
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            errors++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        wb(0, 6'h00, 0);
        chk("ctrl_reset", rdat, 32'h0);
        // Run about 0x143 ticks, halt, latch high byte, then run on
        wb(1, 6'h00, 32'h1);
        wb(1, 6'h04, 0);
        repeat (320) @(posedge clk_sys);
        wb(1, 6'h00, 0);
        wb(0, 6'h04, 0);
        wb(1, 6'h00, 32'h1);
        repeat (512) @(posedge clk_sys);
        wb(1, 6'h00, 0);
        wb(0, 6'h08, 0);
        chk("hi_latched", rdat, 32'h1);
        wb(0, 6'h04, 0);
        wb(0, 6'h08, 0);
        chk("hi_fresh", rdat, 32'h3);
        wb(1, 6'h04, 32'h55);
        repeat (50) @(posedge clk_sys);
        wb(0, 6'h04, 0);
        chk("lo_cleared", rdat, 32'h0);
        for (int p = 0; p < 4; p++) begin
            int ex;
            ex = 203 >> ((p == 0) ? 0 : 2 * p + 1);
            wb(1, 6'h00, 32'(p * 4 + 1));
            wb(1, 6'h04, 0);
            repeat (200) @(posedge clk_sys);
            wb(1, 6'h00, 0);
            wb(0, 6'h04, 0);
            chk("prescale", rdat, 32'(ex));
        end
        wb(1, 6'h20, 32'h10);
        wb(1, 6'h18, 32'h44);
        wb(1, 6'h1C, 32'h08);
        chk("pin_oe", 32'(poe), 32'h2);
        wb(1, 6'h04, 0);
        wb(1, 6'h00, 32'h2);
        repeat (40) @(posedge clk_sys);
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (40) @(posedge clk_sys);
        wb(0, 6'h00, 0);
        chk("flags", rdat, 32'hD2);
        wb(0, 6'h04, 0);
        chk("modulo_max", 32'(rdat <= 32'h10), 32'h1);
        chk("irq_masked", 32'(irq), 32'h0);
        wb(1, 6'h0C, 32'h1);
        repeat (2) @(posedge clk_sys);
        chk("irq_pending", 32'(irq), 32'h1);
        wb(1, 6'h00, 32'hF0);
        wb(1, 6'h00, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk("irq_cleared", 32'(irq), 32'h0);
        wb(1, 6'h04, 0);
        wb(1, 6'h00, 32'h1);
        repeat (65600) @(posedge clk_sys);
        wb(0, 6'h00, 0);
        chk("ovf_free", rdat & 32'h10, 32'h10);
        wb(0, 6'h04, 0);
        chk("wrapped", 32'(rdat < 32'h80), 32'h1);
        chk("irq_free", 32'(irq), 32'h1);
        pin0 = pout;
        wb(1, 6'h00, 32'h3);
        wb(1, 6'h04, 0);
        repeat (17) @(posedge clk_sys);
        wb(1, 6'h00, 0);
        wb(0, 6'h04, 0);
        chk("updown", rdat, 32'hC);
        chk("pin_toggle", 32'(pout ^ pin0), 32'h2);
        wb(0, 6'h2C, 0);
        final_report();
    end
endmodule : tb_top
`default_nettype wire
